// [hdl/sfrx_bank_select.v]
// sfrx_bank_select.v - one module bank register with four write-only save slots
// assumes the caller decodes the address and gives a one-cycle write strobe
`timescale 1ns/1ps
`default_nettype none
`include "sfrx_consts.vh"

module sfrx_bank_select #(
  parameter PAGE_W = 3
) (
  // clock and reset
  input  wire              i_core_clk,
  input  wire              i_sys_rst,
  // write port
  input  wire              i_wr,
  input  wire [7:0]        i_wdata,
  // state out
  output wire [7:0]        o_rdata,
  output wire [PAGE_W-1:0] o_page
);

  reg  [PAGE_W-1:0] page_reg;
  reg  [PAGE_W-1:0] page_next;
  reg  [PAGE_W-1:0] slot_reg [0:3];
  wire [1:0]        op   = i_wdata[`SFRX_OP_MSB:`SFRX_OP_LSB];
  wire [1:0]        slot = i_wdata[`SFRX_SLOT_MSB:`SFRX_SLOT_LSB];
  wire [PAGE_W-1:0] wpage = i_wdata[`SFRX_PAGE_LSB+PAGE_W-1:`SFRX_PAGE_LSB];
  genvar g;

  always @* begin
    page_next = page_reg;
    if (i_wr) begin
      if (op == `SFRX_OP_RESTORE)
        page_next = slot_reg[slot];
      else
        page_next = wpage;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst)
      page_reg <= {PAGE_W{1'b0}};
    else
      page_reg <= page_next;
  end

  // slots are written only on a save, so they keep the page seen before the write
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_slot
      always @(posedge i_core_clk) begin
        if (i_sys_rst)
          slot_reg[g] <= {PAGE_W{1'b0}};
        else if (i_wr && op == `SFRX_OP_SAVE && slot == g)
          slot_reg[g] <= page_reg;
      end
    end
  endgenerate

  assign o_page  = page_reg;
  assign o_rdata = {{(8-PAGE_W){1'b0}}, page_reg};

endmodule
`default_nettype wire

// [hdl/sfrx_top.v]
// sfrx_top.v - sfr area select, module bank registers and guarded control bits
// assumes a cpu sfr port: address, write strobe, write data, combinational read data
`timescale 1ns/1ps
`default_nettype none
`include "sfrx_consts.vh"

module sfrx_top #(
  parameter N_BANKS = 4,
  parameter PAGE_W  = 3,
  parameter [8*N_BANKS-1:0] BANK_ADDRS = 32'hB1B2B3B4,
  parameter [7:0] GUARD_ADDR = 8'hBA
) (
  // clock and reset
  input  wire                      i_core_clk,
  input  wire                      i_sys_rst,
  // sfr port
  input  wire [7:0]                i_sfr_addr,
  input  wire                      i_sfr_wr,
  input  wire [7:0]                i_sfr_wdata,
  output reg  [7:0]                o_sfr_rdata,
  output wire                      o_sfr_hit,
  // area and pages
  output wire                      o_sfr_area_select,
  output wire [N_BANKS*PAGE_W-1:0] o_bank_pages,
  // guarded bits
  output wire [2:0]                o_clock_divider_setting,
  output wire                      o_watchdog_enable_bit,
  output wire                      o_power_down_request,
  output wire                      o_slow_down_request,
  output wire                      o_guard_locked
);

  reg        area_reg;
  reg        rsvd_reg;
  reg  [5:0] guarded_reg;
  wire       hit_ctl   = (i_sfr_addr == `SFRX_ADDR_SYSTEM_CONTROL_ZERO);
  wire       hit_pw    = (i_sfr_addr == `SFRX_ADDR_PASSWORD);
  wire       hit_guard = (i_sfr_addr == GUARD_ADDR);
  wire [7:0] pw_rdata;
  wire [8*N_BANKS-1:0] bank_rdata;
  wire [N_BANKS-1:0]   bank_hit;
  integer k;
  genvar g;

  // control zero answers in either area, so area select can always be undone
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      area_reg <= 1'b0;
      rsvd_reg <= `SFRX_RSVD_RW_RESET;
    end else if (i_sfr_wr && hit_ctl) begin
      area_reg <= i_sfr_wdata[`SFRX_AREA_SEL_BIT];
      rsvd_reg <= i_sfr_wdata[`SFRX_RSVD_RW_BIT];
    end
  end
  assign o_sfr_area_select = area_reg;

  generate
    for (g = 0; g < N_BANKS; g = g + 1) begin : g_bank
      assign bank_hit[g] = (i_sfr_addr == BANK_ADDRS[8*g+7:8*g]);
      sfrx_bank_select #(
        .PAGE_W (PAGE_W)
      ) u_bank (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_wr       (i_sfr_wr && bank_hit[g]),
        .i_wdata    (i_sfr_wdata),
        .o_rdata    (bank_rdata[8*g+7:8*g]),
        .o_page     (o_bank_pages[PAGE_W*g+PAGE_W-1:PAGE_W*g])
      );
    end
  endgenerate

  sfrx_write_guard u_guard (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr       (i_sfr_wr && hit_pw),
    .i_wdata    (i_sfr_wdata),
    .o_rdata    (pw_rdata),
    .o_locked   (o_guard_locked)
  );

  // guarded bits: [2:0] divider, [3] watchdog, [4] power down, [5] slow down
  always @(posedge i_core_clk) begin
    if (i_sys_rst)
      guarded_reg <= 6'h00;
    else if (i_sfr_wr && hit_guard && !o_guard_locked)
      guarded_reg <= i_sfr_wdata[5:0];
  end
  assign o_clock_divider_setting = guarded_reg[2:0];
  assign o_watchdog_enable_bit   = guarded_reg[3];
  assign o_power_down_request    = guarded_reg[4];
  assign o_slow_down_request     = guarded_reg[5];

  assign o_sfr_hit = hit_ctl | hit_pw | hit_guard | (|bank_hit);

  always @* begin
    o_sfr_rdata = 8'h00;
    if (hit_ctl)
      o_sfr_rdata = {5'h00, rsvd_reg, 1'b0, area_reg};
    else if (hit_pw)
      o_sfr_rdata = pw_rdata;
    else if (hit_guard)
      o_sfr_rdata = {2'h0, guarded_reg};
    for (k = 0; k < N_BANKS; k = k + 1) begin
      if (bank_hit[k])
        o_sfr_rdata = bank_rdata[8*k +: 8];
    end
  end

endmodule
`default_nettype wire

// [hdl/sfrx_write_guard.v]
// sfrx_write_guard.v - password register, guard mode and 32-cycle open window
// assumes a one-cycle write strobe on the core clock
`timescale 1ns/1ps
`default_nettype none
`include "sfrx_consts.vh"

module sfrx_write_guard (
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_sys_rst,
  // write port
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  // state out
  output wire [7:0] o_rdata,
  output wire       o_locked
);

  localparam [`SFRX_WIN_W-1:0] WIN_LOAD = `SFRX_OPEN_CYCLES;

  reg  [1:0]             mode_reg;
  reg  [`SFRX_WIN_W-1:0] win_reg;
  wire [4:0]             key = i_wdata[`SFRX_KEY_MSB:`SFRX_KEY_LSB];
  wire                   enabled = (mode_reg != `SFRX_MODE_OFF);

  always @(posedge i_core_clk) begin
    if (i_sys_rst)
      mode_reg <= `SFRX_MODE_RESET;
    else if (i_wr && key == `SFRX_KEY_MODE)
      mode_reg <= i_wdata[`SFRX_MODE_MSB:`SFRX_MODE_LSB];
  end

  // the window counts the cycles left open; zero means closed
  always @(posedge i_core_clk) begin
    if (i_sys_rst)
      win_reg <= {`SFRX_WIN_W{1'b0}};
    else if (i_wr && enabled && key == `SFRX_KEY_OPEN)
      win_reg <= WIN_LOAD;
    else if (i_wr && enabled && key == `SFRX_KEY_CLOSE)
      win_reg <= {`SFRX_WIN_W{1'b0}};
    else if (win_reg != {`SFRX_WIN_W{1'b0}})
      win_reg <= win_reg - 1'b1;
  end

  assign o_locked = enabled && (win_reg == {`SFRX_WIN_W{1'b0}});
  assign o_rdata  = {5'h00, o_locked, mode_reg};

endmodule
`default_nettype wire

// [inc/sfrx_consts.vh]
// sfrx_consts.vh - constants for the sfr address extension and write guard block
// assumes an 8-bit sfr bus with a write strobe on the core clock and combinational read data
//
// Notes on behaviour
// - area select clear steers to standard area, set steers to mapped area; bit 0.
// - area select bit is never cleared by hardware.
// - bit 2 of system control zero is reserved read/write, returns last value.
// - bits 1, 7..3 of control zero and bit 3 of bank register read zero.
// - bank select field takes written page; read returns active page.
// - save slot number field bits 5..4 picks one of four slots.
// - manual operation loads written page directly, slot number ignored.
// - operation 10 saves old page to slot and loads new page.
// - operation 11 restores page from slot, written page ignored.
// - mode field disables guard only at 00; any other value enables it.
// - mode field changes only on password write with key 11000.
// - with guard enabled, key 10011 opens guarded writes.
// - with guard enabled, key 10101 closes guarded writes.
// - open and close keys never alter the mode field.
// - open window closes itself after at most 32 core clocks.
// - open key while open restarts the 32-cycle window.
// - guarded bits cannot be written while access is closed.
// - protection status bit 2 reads 0 when writable, 1 when locked.
// - any other key value has no effect.
// - control zero sits at 8F and is reachable in both areas.
`ifndef SFRX_CONSTS_VH
`define SFRX_CONSTS_VH

`define SFRX_ADDR_SYSTEM_CONTROL_ZERO    8'h8F
`define SFRX_ADDR_PASSWORD   8'hBB
`define SFRX_AREA_SEL_BIT    0
`define SFRX_RSVD_RW_BIT     2
`define SFRX_RSVD_RW_RESET   1'b1
`define SFRX_PAGE_LSB        0
`define SFRX_PAGE_MSB        2
`define SFRX_SLOT_LSB        4
`define SFRX_SLOT_MSB        5
`define SFRX_OP_LSB          6
`define SFRX_OP_MSB          7
`define SFRX_OP_SAVE         2'h2
`define SFRX_OP_RESTORE      2'h3
`define SFRX_MODE_LSB        0
`define SFRX_MODE_MSB        1
`define SFRX_STATUS_BIT      2
`define SFRX_KEY_LSB         3
`define SFRX_KEY_MSB         7
`define SFRX_KEY_MODE        5'h18
`define SFRX_KEY_OPEN        5'h13
`define SFRX_KEY_CLOSE       5'h15
`define SFRX_MODE_OFF        2'h0
`define SFRX_MODE_RESET      2'h3
`define SFRX_OPEN_CYCLES     6'h20
`define SFRX_WIN_W           6

`endif

// [tb/sfrx_checker.sv]
// sfrx_checker.sv - assertions on the sfr port and state outputs of sfrx_top
// assumes it is bound to sfrx_top; one core clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module sfrx_checker #(
  parameter N_BANKS = 4,
  parameter PAGE_W  = 3
) (
  input wire                      i_core_clk,
  input wire                      i_sys_rst,
  input wire [7:0]                i_sfr_addr,
  input wire                      i_sfr_wr,
  input wire [7:0]                i_sfr_wdata,
  input wire [7:0]                o_sfr_rdata,
  input wire                      o_sfr_hit,
  input wire                      o_sfr_area_select,
  input wire [N_BANKS*PAGE_W-1:0] o_bank_pages,
  input wire [2:0]                o_clock_divider_setting,
  input wire                      o_watchdog_enable_bit,
  input wire                      o_power_down_request,
  input wire                      o_slow_down_request,
  input wire                      o_guard_locked
);
  wire       pw = i_sfr_wr && i_sfr_addr == 8'hBB;
  wire [5:0] gb = {o_slow_down_request, o_power_down_request,
                   o_watchdog_enable_bit, o_clock_divider_setting};
  reg  [5:0] cnt_reg;
  // age of the open window; any other password write or a disabled mode stops tracking
  always @(posedge i_core_clk)
    if (i_sys_rst || (pw && (i_sfr_wdata[7:3] != 5'h13 || o_sfr_rdata[1:0] == 2'h0)))
      cnt_reg <= 6'h00;
    else if (pw)
      cnt_reg <= 6'h01;
    else if (cnt_reg != 6'h00 && cnt_reg != 6'h3F)
      cnt_reg <= cnt_reg + 6'h01;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  area_follow_a: assert property (i_sfr_wr && i_sfr_addr == 8'h8F
    |=> {7'h00, o_sfr_area_select} == ($past(i_sfr_wdata) & 8'h01)) else $error("area lost");
  area_hold_a: assert property (!(i_sfr_wr && i_sfr_addr == 8'h8F)
    |=> $stable(o_sfr_area_select)) else $error("area moved");
  status_read_a: assert property (i_sfr_addr == 8'hBB
    |-> o_sfr_rdata[7:2] == {5'h00, o_guard_locked}) else $error("status wrong");
  guard_block_a: assert property (i_sfr_wr && i_sfr_addr == 8'hBA && o_guard_locked
    |=> $stable(gb)) else $error("locked bits written");
  guard_write_a: assert property (i_sfr_wr && i_sfr_addr == 8'hBA && !o_guard_locked
    |=> {2'h0, gb} == ($past(i_sfr_wdata) & 8'h3F)) else $error("open write lost");
  window_open_a: assert property (cnt_reg != 6'h00 && cnt_reg < 6'h21
    |-> !o_guard_locked) else $error("window shut early");
  window_shut_a: assert property (cnt_reg == 6'h21
    |-> o_guard_locked) else $error("window overran");
  bank_manual_a: assert property (i_sfr_wr && i_sfr_addr == 8'hB4 && i_sfr_wdata[7:6] == 2'h0
    |=> {5'h00, o_bank_pages[2:0]} == ($past(i_sfr_wdata) & 8'h07)) else $error("page lost");
  hit_decode_a: assert property (1'b1
    |-> o_sfr_hit == (i_sfr_addr == 8'h8F || i_sfr_addr == 8'hBB || i_sfr_addr == 8'hBA
                      || (i_sfr_addr >= 8'hB1 && i_sfr_addr <= 8'hB4)))
    else $error("hit decode wrong");
  page_view_a: assert property (i_sfr_addr >= 8'hB1 && i_sfr_addr <= 8'hB4
    |-> o_sfr_rdata == {5'h00, o_bank_pages[3 * (8'hB4 - i_sfr_addr) +: 3]})
    else $error("page view wrong");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// tb_top.sv - self-checking bench for sfrx_top through its sfr port
// assumes sfrx_top and sfrx_checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  reg         i_core_clk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg  [7:0]  i_sfr_addr = 8'h00;
  reg         i_sfr_wr = 1'b0;
  reg  [7:0]  i_sfr_wdata = 8'h00;
  reg         rd_chk = 1'b0;
  wire [7:0]  o_sfr_rdata;
  integer     err_count = 0, compares = 0, seed = 32'h101AC36B, i, g;
  reg  [7:0]  d, a;
  reg  [2:0]  pg [0:3];
  reg  [2:0]  st [0:15];
  logic [7:0] exp_q [$];
  sfrx_top uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(),
    .o_sfr_area_select(), .o_bank_pages(), .o_clock_divider_setting(),
    .o_watchdog_enable_bit(), .o_power_down_request(), .o_slow_down_request(),
    .o_guard_locked());
  initial forever #50 i_core_clk = ~i_core_clk;
  task wr(input [7:0] ad, input [7:0] v);
    @(posedge i_core_clk);
    i_sfr_addr <= ad;
    i_sfr_wdata <= v;
    i_sfr_wr <= 1'b1;
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task rd(input [7:0] ad, input [7:0] e);
    @(posedge i_core_clk);
    i_sfr_addr <= ad;
    rd_chk <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_core_clk);
    rd_chk <= 1'b0;
  endtask
  task cmp_rd(input [7:0] e);
    compares = compares + 1;
    if (o_sfr_rdata !== e) begin
      err_count = err_count + 1;
      $display("BAD o_sfr_rdata exp %h got %h", e, o_sfr_rdata);
    end
  endtask
  task tally_and_finish;
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // read data is combinational, so the settled value is taken mid-cycle
  always @(negedge i_core_clk) if (rd_chk) cmp_rd(exp_q.pop_front());
  initial begin
    repeat (3000) @(posedge i_core_clk);
    err_count = err_count + 1;
    tally_and_finish;
  end
  initial begin
    for (i = 0; i < 16; i = i + 1) st[i] = 3'h0;
    for (i = 0; i < 4; i = i + 1) pg[i] = 3'h0;
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(8'h8F, 8'h04);
    rd(8'hBB, 8'h07);
    rd(8'hB2, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'hBA, 8'h3F);
    rd(8'hBA, 8'h00);
    wr(8'h8F, 8'hFF);
    rd(8'h8F, 8'h05);
    wr(8'h8F, 8'h00);
    rd(8'h8F, 8'h00);
    // from here on software style: reserved bit kept at one, area select or-ed in and and-ed out
    wr(8'h8F, 8'h04);
    wr(8'h8F, 8'h05);
    rd(8'h8F, 8'h05);
    wr(8'h8F, 8'h04);
    rd(8'h8F, 8'h04);
    wr(8'hBB, 8'h98);
    wr(8'hBA, 8'h2A);
    wr(8'hBB, 8'hA8);
    rd(8'hBB, 8'h07);
    wr(8'hBA, 8'h15);
    rd(8'hBA, 8'h2A);
    // reopen part-way so only the restarted window keeps the bits open
    wr(8'hBB, 8'h98);
    repeat (20) @(posedge i_core_clk);
    wr(8'hBB, 8'h98);
    // first read lands in the last open cycle of the window, the second one cycle after the edge it shuts
    repeat (30) @(posedge i_core_clk);
    rd(8'hBB, 8'h03);
    rd(8'hBB, 8'h07);
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      // nudge any of the three live keys onto a dead neighbour
      if (d[7:3] == 5'h18 || d[7:3] == 5'h13 || d[7:3] == 5'h15) d[3] = ~d[3];
      wr(8'hBB, d);
      rd(8'hBB, 8'h07);
    end
    wr(8'hBB, 8'hC0);
    rd(8'hBB, 8'h00);
    wr(8'hBA, 8'h15);
    wr(8'hBB, 8'h98);
    rd(8'hBB, 8'h00);
    rd(8'hBA, 8'h15);
    wr(8'hBB, 8'hC1);
    rd(8'hBB, 8'h05);
    wr(8'hBB, 8'hC3);
    rd(8'hBB, 8'h07);
    for (i = 0; i < 48; i = i + 1) begin
      g = i % 4;
      a = 8'hB4 - g[7:0];
      d = $random(seed);
      // operation 01 has no defined meaning, so it is kept out
      if (d[7:6] == 2'h1) d[6] = 1'b0;
      if (d[7:6] == 2'h3) pg[g] = st[g * 4 + d[5:4]];
      else begin
        if (d[7]) st[g * 4 + d[5:4]] = pg[g];
        pg[g] = d[2:0];
      end
      wr(a, d);
      rd(a, {5'h00, pg[g]});
    end
    repeat (2) @(posedge i_core_clk);
    tally_and_finish;
  end
endmodule
bind sfrx_top sfrx_checker #(.N_BANKS(N_BANKS), .PAGE_W(PAGE_W)) u_chk (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
  .o_sfr_hit(o_sfr_hit),
  .o_sfr_area_select(o_sfr_area_select), .o_bank_pages(o_bank_pages),
  .o_clock_divider_setting(o_clock_divider_setting), .o_guard_locked(o_guard_locked),
  .o_watchdog_enable_bit(o_watchdog_enable_bit), .o_power_down_request(o_power_down_request),
  .o_slow_down_request(o_slow_down_request));
`default_nettype wire
